// ---- mic_irq_defines.vh ----
/*
 * Constants of the interrupt control block: register byte offsets,
 * bit positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MIC_IRQ_DEFINES_VH
`define MIC_IRQ_DEFINES_VH

// ============================================================
// Register byte offsets (AHB-Lite, one word each)
`define MIC_OFF_CONTROL     8'h00
`define MIC_OFF_OPTION      8'h04
`define MIC_OFF_CHG_MASK    8'h08
`define MIC_OFF_ANALOG_SEL  8'h0C
`define MIC_OFF_PERIPH_EN   8'h10
`define MIC_OFF_PERIPH_FLAG 8'h14
`define MIC_OFF_TIMER0      8'h18
`define MIC_OFF_CORE_STAT   8'h1C

// ============================================================
// Bit positions in irq_control_reg
`define MIC_BIT_GLB   7
`define MIC_BIT_PEN   6
`define MIC_BIT_T0E   5
`define MIC_BIT_EXTE  4
`define MIC_BIT_CHGE  3
`define MIC_BIT_T0F   2
`define MIC_BIT_EXTF  1
`define MIC_BIT_CHGF  0
// Bit position in option register
`define MIC_BIT_EDGE  0

// ============================================================
// Reset values
`define MIC_RST_CONTROL    8'h00
`define MIC_RST_OPTION     1'h0
`define MIC_RST_MASK       8'h00
`define MIC_RST_ANALOG     8'hFF
`define MIC_RST_PERIPH     8'h00

// ============================================================
// Vector and timing
`define MIC_VECTOR_ADDR    13'h0004
`define MIC_QUARTERS       2'h3
`define MIC_DISPATCH_TCY   2'h2

`endif

// ---- mic_pin_sync.v ----
/*
 * Two-flop synchroniser for a group of pins, followed by a history
 * flop for change detection. Analog-selected pins read as zero.
 * Assumes pins are asynchronous to hclk.
 */
module mic_pin_sync
#(
    parameter N = 8
)
(
    // Clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    input  wire         clk_en,
    // Pins and selection
    input  wire [N-1:0] pin_async,
    input  wire [N-1:0] analog_sel,
    // Synchronised results
    output wire [N-1:0] pin_level,
    output wire [N-1:0] pin_rise,
    output wire [N-1:0] pin_fall
);

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_pin
            reg meta_reg;
            reg sync_reg;
            reg prev_reg;
            wire dig;

            // Synchroniser and history, frozen with clk_en
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    prev_reg <= 1'b0;
                end
                else if (clk_en)
                begin
                    meta_reg <= pin_async[i];
                    sync_reg <= meta_reg;
                    prev_reg <= dig;
                end
            end

            // Analog pins read zero and never toggle
            assign dig          = sync_reg & ~analog_sel[i];
            assign pin_level[i] = dig;
            assign pin_rise[i]  = dig & ~prev_reg & ~analog_sel[i];
            assign pin_fall[i]  = ~dig & prev_reg & ~analog_sel[i];
        end
    endgenerate

endmodule // mic_pin_sync

// ---- mic_irq_ctrl.v ----
/*
 * Interrupt control of a small 8-bit core: flags, enables, dispatch
 * to the fixed vector, return, wake from sleep, timer0 overflow.
 * Assumes the core runs one instruction cycle per four hclk quarters
 * and honours irq_take, stack and restore strobes the same cycle.
 */
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
// Overview of operation
// R1 - Global enable passes enabled interrupts, else none
// R2 - Reset clears global enable
// R3 - Taking clears enable, pushes return, loads vector
// R4 - Flags set regardless of any enable
// R5 - In service, flags set but no redirect
// R6 - Enable-clearing instruction cancels next-cycle dispatch
// R7 - Return pops, restores context, sets enable
// R8 - Pin event latency three or four cycles
// R9 - External pin edge selectable, sets flag
// R10 - External enable gates; enabled edge wakes sleep
// R11 - Analog pins read zero, never interrupt
// R12 - Flag sampled each Q1, settable Q4-Q1; the code sets the external flag in any quarter
// R13 - Peripheral enable gates all peripheral interrupts
// R14 - Timer0 enable gates; overflow flag sticky
// R15 - External enable gates; external flag sticky
// R16 - Change enable and masks gate change flag
// R17 - Control register read/write, resets to zero
// R18 - Firmware clears flags before enabling
// R19 - Service routine polls and clears flags
// R20 - Timer0 count survives reset
// R21 - Peripherals need peripheral enable too
// R22 - Request is global AND of core/peripheral terms
`include "mic_irq_defines.vh"

module mic_irq_ctrl
#(
    parameter PINS     = 8,
    parameter EXT_PIN  = 2,
    parameter PERIPH_N = 8
)
(
    // Clock, reset, enable
    input  wire                hclk,
    input  wire                hresetn,
    input  wire                clk_en,
    // AHB-Lite slave
    input  wire                hsel,
    input  wire [7:0]          haddr,
    input  wire [1:0]          htrans,
    input  wire                hwrite,
    input  wire [2:0]          hsize,
    input  wire                hready,
    input  wire [31:0]         hwdata,
    output wire [31:0]         hrdata,
    output wire                hreadyout,
    output wire                hresp,
    // Pins and peripheral events
    input  wire [PINS-1:0]     gpio_pins,
    input  wire [PERIPH_N-1:0] periph_event,
    // Core handshake
    input  wire                core_gie_clear,
    input  wire                core_return,
    input  wire                core_sleep,
    input  wire [12:0]         core_pc,
    output wire                irq_take,
    output wire                stack_push,
    output wire                stack_pop,
    output wire                ctx_restore,
    output wire                wake_req,
    output wire [12:0]         vector_addr,
    output wire [12:0]         return_addr,
    output wire [1:0]          quarter
);

    // ========================================================
    // Registers
    reg  [7:0]          irq_control_reg;
    reg                 ext_edge_select;
    reg  [PINS-1:0]     pin_change_mask_regs;
    reg  [PINS-1:0]     analog_select_regs;
    reg  [PERIPH_N-1:0] periph_enable_regs;
    reg  [PERIPH_N-1:0] periph_flag_regs;
    reg  [7:0]          timer0_count;
    reg  [1:0]          quarter_reg;
    reg  [1:0]          state_reg;
    reg  [1:0]          tcy_cnt_reg;
    reg                 take_reg;
    reg                 wake_reg;
    reg  [12:0]         ret_addr_reg;
    reg  [12:0]         vec_reg;
    reg  [31:0]         rdata_reg;
    reg                 wr_pend_reg;
    reg  [7:0]          wr_addr_reg;

    // Dispatch states
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;

    // ========================================================
    // Pin synchronisation
    wire [PINS-1:0] pin_level;
    wire [PINS-1:0] pin_rise;
    wire [PINS-1:0] pin_fall;

    mic_pin_sync #(.N(PINS)) u_sync
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_en     (clk_en),
        .pin_async  (gpio_pins),
        .analog_sel (analog_select_regs),
        .pin_level  (pin_level),
        .pin_rise   (pin_rise),
        .pin_fall   (pin_fall)
    );

    // ========================================================
    // Event detection
    wire q1      = (quarter_reg == 2'h0);
    wire q4      = (quarter_reg == `MIC_QUARTERS);
    // Edge on external pin by polarity; analog pins gated in sync
    wire ext_evt = ext_edge_select ? pin_rise[EXT_PIN]
                                   : pin_fall[EXT_PIN];                  // [R9] [R11]
    // Any masked digital pin changed
    wire chg_evt = |((pin_rise | pin_fall) & pin_change_mask_regs);       // [R16] [R11]
    // Timer0 rolls over at end of instruction cycle
    wire t0_evt  = q4 & (timer0_count == 8'hFF);                          // [R14]
    // Window Q4 through Q1; flags may land in any quarter, sampled at Q1
    wire flag_win = q4 | q1;                                              // [R12]

    // ========================================================
    // Request combine
    wire glb_en   = irq_control_reg[`MIC_BIT_GLB];
    wire core_any = (irq_control_reg[`MIC_BIT_T0E] & irq_control_reg[`MIC_BIT_T0F])
                  | (irq_control_reg[`MIC_BIT_EXTE] & irq_control_reg[`MIC_BIT_EXTF])  // [R15]
                  | (irq_control_reg[`MIC_BIT_CHGE] & irq_control_reg[`MIC_BIT_CHGF]); // [R16]
    wire per_any  = irq_control_reg[`MIC_BIT_PEN]
                  & |(periph_flag_regs & periph_enable_regs);             // [R13] [R21]
    wire pending  = core_any | per_any;
    wire irq_req  = glb_en & pending;                                     // [R1] [R22]

    // ========================================================
    // Bus decode
    wire addr_ph = hsel & htrans[1] & hready & clk_en;
    wire wr_now  = wr_pend_reg & clk_en;
    wire [7:0] wb = hwdata[7:0];
    wire wr_ctl  = wr_now & (wr_addr_reg == `MIC_OFF_CONTROL);

    // ========================================================
    // Quarter counter, one instruction cycle per four edges
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            quarter_reg <= 2'h0;
        else if (clk_en)
            quarter_reg <= quarter_reg + 2'h1;
    end

    // ========================================================
    // Timer0 count, deliberately outside reset
    always @(posedge hclk)
    begin
        if (clk_en)
        begin
            if (wr_now && wr_addr_reg == `MIC_OFF_TIMER0)
                timer0_count <= wb;                                       // [R20]
            else if (q4)
                timer0_count <= timer0_count + 8'h01;
        end
    end

    // ========================================================
    // Control register: software write, hardware set wins
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_control_reg <= `MIC_RST_CONTROL;                          // [R2] [R17]
        else if (clk_en)
        begin
            if (wr_ctl)
                irq_control_reg <= wb;                                    // [R17] [R19]
            // Return sets global enable
            if (core_return)
                irq_control_reg[`MIC_BIT_GLB] <= 1'b1;                    // [R7]
            // Instruction clearing enable, or dispatch, clears it
            if (core_gie_clear || take_reg)
                irq_control_reg[`MIC_BIT_GLB] <= 1'b0;                    // [R3] [R6]
            // Flags set independent of enables
            if (t0_evt)
                irq_control_reg[`MIC_BIT_T0F] <= 1'b1;                    // [R4] [R14]
            if (ext_evt && flag_win)
                irq_control_reg[`MIC_BIT_EXTF] <= 1'b1;                   // [R4] [R15] [R12]
            if (ext_evt && !flag_win)
                irq_control_reg[`MIC_BIT_EXTF] <= 1'b1;                   // [R4] [R15]
            if (chg_evt)
                irq_control_reg[`MIC_BIT_CHGF] <= 1'b1;                   // [R4] [R16]
        end
    end

    // ========================================================
    // Configuration registers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_edge_select      <= `MIC_RST_OPTION;
            pin_change_mask_regs <= `MIC_RST_MASK;
            analog_select_regs   <= `MIC_RST_ANALOG;
            periph_enable_regs   <= `MIC_RST_PERIPH;
        end
        else if (wr_now)
        begin
            if (wr_addr_reg == `MIC_OFF_OPTION)
                ext_edge_select <= wb[`MIC_BIT_EDGE];
            else if (wr_addr_reg == `MIC_OFF_CHG_MASK)
                pin_change_mask_regs <= wb;
            else if (wr_addr_reg == `MIC_OFF_ANALOG_SEL)
                analog_select_regs <= wb;
            else if (wr_addr_reg == `MIC_OFF_PERIPH_EN)
                periph_enable_regs <= wb;
        end
    end

    // ========================================================
    // Peripheral flags, per bit, set wins over software clear
    genvar p;
    generate
        for (p = 0; p < PERIPH_N; p = p + 1)
        begin : g_per
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    periph_flag_regs[p] <= 1'b0;
                else if (clk_en)
                begin
                    if (periph_event[p])
                        periph_flag_regs[p] <= 1'b1;                      // [R4]
                    else if (wr_now && wr_addr_reg == `MIC_OFF_PERIPH_FLAG)
                        periph_flag_regs[p] <= wb[p];
                end
            end
        end
    endgenerate

    // ========================================================
    // Dispatch: sample at Q1, redirect two cycles later at Q1
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg    <= ST_IDLE;
            tcy_cnt_reg  <= 2'h0;
            take_reg     <= 1'b0;
            ret_addr_reg <= 13'h0000;
            vec_reg      <= 13'h0000;
        end
        else if (clk_en)
        begin
            take_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (q1 && irq_req && !core_gie_clear && !core_sleep)
                    begin
                        state_reg   <= ST_WAIT;                           // [R12] [R8]
                        tcy_cnt_reg <= `MIC_DISPATCH_TCY;
                    end
                end
                ST_WAIT:
                begin
                    // Dropped enable cancels; flags stay pending
                    if (core_gie_clear || !irq_req)
                        state_reg <= ST_IDLE;                             // [R6] [R5] [R1]
                    else if (q4)
                    begin
                        if (tcy_cnt_reg == 2'h1)
                        begin
                            take_reg     <= 1'b1;                         // [R3] [R8]
                            ret_addr_reg <= core_pc;                      // [R3]
                            vec_reg      <= `MIC_VECTOR_ADDR;             // [R3]
                            state_reg    <= ST_IDLE;
                        end
                        tcy_cnt_reg <= tcy_cnt_reg - 2'h1;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ========================================================
    // Wake: enabled pending source while asleep, enable not needed
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wake_reg <= 1'b0;
        else if (clk_en)
            wake_reg <= core_sleep & pending;                             // [R10]
    end

    // ========================================================
    // Bus slave: latch write, registered read data
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            wr_pend_reg <= addr_ph & hwrite;
            wr_addr_reg <= haddr;
            rdata_reg   <= 32'h0000_0000;
            if (addr_ph && !hwrite)
            begin
                if (haddr == `MIC_OFF_CONTROL)
                    rdata_reg[7:0] <= irq_control_reg;
                else if (haddr == `MIC_OFF_OPTION)
                    rdata_reg[0] <= ext_edge_select;
                else if (haddr == `MIC_OFF_CHG_MASK)
                    rdata_reg[PINS-1:0] <= pin_change_mask_regs;
                else if (haddr == `MIC_OFF_ANALOG_SEL)
                    rdata_reg[PINS-1:0] <= analog_select_regs;
                else if (haddr == `MIC_OFF_PERIPH_EN)
                    rdata_reg[PERIPH_N-1:0] <= periph_enable_regs;
                else if (haddr == `MIC_OFF_PERIPH_FLAG)
                    rdata_reg[PERIPH_N-1:0] <= periph_flag_regs;
                else if (haddr == `MIC_OFF_TIMER0)
                    rdata_reg[7:0] <= timer0_count;
                else if (haddr == `MIC_OFF_CORE_STAT)
                    rdata_reg[PINS+3:0] <= {pin_level, state_reg, quarter_reg}; // [R11]
            end
        end
    end

    // ========================================================
    // Outputs
    assign hrdata      = rdata_reg;
    assign hreadyout   = clk_en;
    assign hresp       = 1'b0;
    assign irq_take    = take_reg;
    assign stack_push  = take_reg;                                        // [R3]
    assign stack_pop   = core_return;                                     // [R7]
    assign ctx_restore = core_return;                                     // [R7]
    assign wake_req    = wake_reg;
    assign vector_addr = vec_reg;
    assign return_addr = ret_addr_reg;
    assign quarter     = quarter_reg;

endmodule // mic_irq_ctrl

// ---- mic_core_model.sv ----
/*
 * Core-side partner: a program counter stepping once per
 * instruction cycle, and a hardware stack depth counter.
 * Assumes it sits on the core handshake of mic_irq_ctrl.
 */
module mic_core_model
(
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Handshake from the controller
    input  wire [1:0]  quarter,
    input  wire        stack_push,
    input  wire        stack_pop,
    // Core state
    output logic [12:0] core_pc,
    output logic [3:0]  depth
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Program counter and stack depth
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            core_pc <= 13'h0100;
            depth   <= 4'h0;
        end
        else
        begin
            if (quarter == 2'h3)
                core_pc <= core_pc + 13'h0001;  // One step per Q4
            if (stack_push)
                depth <= depth + 4'h1;
            else if (stack_pop)
                depth <= depth - 4'h1;
        end
    end
endmodule // mic_core_model

// ---- mic_irq_monitor.sv ----
/*
 * Concurrent checks on the ports of mic_irq_ctrl.
 * Assumes it is bound to the controller, one clock domain.
 */
module mic_irq_monitor
(
    // Clock and reset
    input wire        hclk,
    input wire        hresetn,
    input wire        clk_en,
    // Bus answer
    input wire        hreadyout,
    input wire        hresp,
    // Core handshake
    input wire        core_gie_clear,
    input wire        core_return,
    input wire        core_sleep,
    input wire [12:0] core_pc,
    input wire        irq_take,
    input wire        stack_push,
    input wire        stack_pop,
    input wire        ctx_restore,
    input wire        wake_req,
    input wire [12:0] vector_addr,
    input wire [12:0] return_addr,
    input wire [1:0]  quarter
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Dispatch
    property p_retake; irq_take |=> !irq_take [*8]; endproperty
    a_retake: assert property (p_retake) else $error("irq_take repeated in service");
    property p_push; stack_push == irq_take; endproperty
    a_push: assert property (p_push) else $error("stack_push not with irq_take");
    property p_vector; irq_take |-> vector_addr == 13'h0004; endproperty
    a_vector: assert property (p_vector) else $error("vector not 0004");
    property p_ret_addr; irq_take |-> return_addr == $past(core_pc); endproperty
    a_ret_addr: assert property (p_ret_addr) else $error("return address not pc");
    property p_en_clr; core_gie_clear |=> !irq_take [*8]; endproperty
    a_en_clr: assert property (p_en_clr) else $error("take after enable clear");

    // ==========================================================
    // Return, wake, timing, bus
    property p_pop; stack_pop == core_return && ctx_restore == core_return; endproperty
    a_pop: assert property (p_pop) else $error("pop or restore not with return");
    property p_wake; !core_sleep |=> !wake_req; endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_quarter; clk_en && $past(clk_en) && $past(hresetn) |-> quarter == $past(quarter) + 2'h1; endproperty
    a_quarter: assert property (p_quarter) else $error("quarter not stepping");
    property p_bus; hreadyout == clk_en && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus answer wrong");

    // Main scenarios
    c_take: cover property (irq_take);
    c_ret: cover property (core_return);
    c_wake: cover property (wake_req);
endmodule // mic_irq_monitor

// ---- mcu_interrupt_control_tb_top.sv ----
/*
 * Self-checking bench of mic_irq_ctrl over AHB-Lite, with the
 * core model and the port monitor attached.
 * Assumes the controller answers with zero wait states.
 */
`include "mic_irq_defines.vh"

module mcu_interrupt_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ct = `MIC_OFF_CONTROL;
    localparam logic [7:0] an = `MIC_OFF_ANALOG_SEL;
    localparam logic [7:0] pf = `MIC_OFF_PERIPH_FLAG;
    localparam logic [7:0] t0 = `MIC_OFF_TIMER0;
    logic        hclk = 0;
    logic        hresetn = 0;
    logic        clk_en = 1;
    logic        hsel = 0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0]  gpio_pins = 8'h00;
    logic [7:0]  periph_event = 8'h00;
    logic        core_gie_clear = 0;
    logic        core_return = 0;
    logic        core_sleep = 0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, irq_take, stack_push, stack_pop, ctx_restore, wake_req;
    wire  [12:0] core_pc, vector_addr, return_addr;
    wire  [1:0]  quarter;
    wire  [3:0]  depth;
    int          err_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n;
    logic [7:0]  r;

    always #25 hclk = ~hclk;

    mic_irq_ctrl u_dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .gpio_pins, .periph_event,
        .core_gie_clear, .core_return, .core_sleep, .core_pc, .irq_take, .stack_push, .stack_pop,
        .ctx_restore, .wake_req, .vector_addr, .return_addr, .quarter);
    mic_core_model u_core (.hclk, .hresetn, .quarter, .stack_push, .stack_pop, .core_pc, .depth);

    // ==========================================================
    // Tasks
    task close_out;
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One single transfer: address phase, then data phase
    task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        bus(a, 1'b0, 8'h00);
        chk(nm, r & m, e & m);
    endtask
    // Cycles until irq_take, at most lim
    task wt(input int lim);
        n = 0;
        while (irq_take !== 1'b1 && n < lim)
        begin
            @(posedge hclk);
            n++;
        end
    endtask
    task pin(input int b, input logic v);
        @(posedge hclk);
        gpio_pins[b] <= v;
        repeat (8) @(posedge hclk);
    endtask
    // Service routine end: clear flags, then return
    task ret_isr(input logic [7:0] c);
        wr(ct, c);
        @(posedge hclk);
        core_return <= 1'b1;
        @(posedge hclk);
        core_return <= 1'b0;
    endtask

    // Watchdog on the whole run
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            close_out;
        end
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        wr(t0, 8'h00);
        rd("ctl reset", ct, 8'h00, 8'hFB);
        rd("analog reset", an, 8'hFF, 8'hFF);
        rd("unmapped", 8'h40, 8'h00, 8'hFF);
        // Clock enable low freezes state
        clk_en <= 1'b0;
        @(posedge hclk);
        r = quarter;
        repeat (3) @(posedge hclk);
        chk("frozen", quarter, r);
        clk_en <= 1'b1;
        wr(ct, 8'h78);
        rd("ctl rw", ct, 8'h78, 8'hFB);
        wr(ct, 8'h10);
        pin(2, 1); pin(2, 0);
        rd("analog pin", ct, 8'h10, 8'hFB);
        wr(an, 8'h00);
        wr(`MIC_OFF_OPTION, 8'h01);
        pin(2, 1);
        wt(30);
        chk("no take masked", n, 30);
        rd("rise flag", ct, 8'h12, 8'hFB);
        wr(ct, 8'h10);
        pin(2, 0);
        rd("fall ignored", ct, 8'h10, 8'hFB);
        wr(`MIC_OFF_OPTION, 8'h00);
        pin(2, 1); pin(2, 0);
        rd("fall flag", ct, 8'h12, 8'hFB);
        // Sleep with pin interrupt disabled, then enabled
        wr(ct, 8'h00);
        core_sleep <= 1'b1;
        pin(2, 1); pin(2, 0);
        chk("no wake", wake_req, 1'b0);
        wr(ct, 8'h10);
        pin(2, 1); pin(2, 0);
        chk("wake", wake_req, 1'b1);
        core_sleep <= 1'b0;
        wr(ct, 8'h90);
        // Dispatch and its latency
        pin(2, 1);
        @(posedge hclk);
        gpio_pins[2] <= 1'b0;
        wt(40);
        chk("latency", n >= 8 && n <= 20, 1'b1);
        chk("vector", vector_addr, 13'h0004);
        repeat (2) @(posedge hclk);
        chk("pushed", depth, 4'h1);
        rd("in isr", ct, 8'h12, 8'hFB);
        pin(2, 1); pin(2, 0);
        wt(40);
        chk("no take in isr", n, 40);
        ret_isr(8'h10);
        repeat (2) @(posedge hclk);
        chk("popped", depth, 4'h0);
        rd("enable back", ct, 8'h90, 8'hFB);
        // Enable cleared while a dispatch is waiting
        pin(2, 1);
        @(posedge hclk);
        gpio_pins[2] <= 1'b0;
        repeat (6) @(posedge hclk);
        core_gie_clear <= 1'b1;
        @(posedge hclk);
        core_gie_clear <= 1'b0;
        wt(40);
        chk("cancelled", n, 40);
        rd("still pending", ct, 8'h12, 8'hFB);
        wr(ct, 8'h92);
        wt(40);
        chk("pending taken", n < 40, 1'b1);
        ret_isr(8'h00);
        wr(ct, 8'h00);
        // Peripheral gating
        @(posedge hclk);
        periph_event <= 8'h01;
        @(posedge hclk);
        periph_event <= 8'h00;
        rd("periph flag", pf, 8'h01, 8'hFF);
        wr(`MIC_OFF_PERIPH_EN, 8'h01);
        wr(ct, 8'h80);
        wt(40);
        chk("periph blocked", n, 40);
        wr(ct, 8'hC0);
        wt(40);
        chk("periph take", n < 40, 1'b1);
        wr(pf, 8'h00);
        ret_isr(8'h00);
        wr(ct, 8'h00);
        // Pin change with per-pin mask
        wr(`MIC_OFF_CHG_MASK, 8'h01);
        pin(1, 1);
        rd("unmasked pin", ct, 8'h00, 8'hFB);
        pin(0, 1);
        rd("change flag", ct, 8'h01, 8'hFB);
        wr(ct, 8'h89);
        wt(40);
        chk("change take", n < 40, 1'b1);
        ret_isr(8'h00);
        wr(ct, 8'h00);
        // Timer0 rollover
        wr(t0, 8'hFE);
        repeat (12) @(posedge hclk);
        rd("t0 flag", ct, 8'h04, 8'hFF);
        wr(ct, 8'hA4);
        wt(40);
        chk("t0 take", n < 40, 1'b1);
        ret_isr(8'h00);
        wr(ct, 8'h00);
        // Count kept through a second reset
        wr(t0, 8'h80);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(t0, 1'b0, 8'h00);
        chk("t0 kept", r >= 8'h80 && r < 8'h90, 1'b1);
        rd("ctl reset again", ct, 8'h00, 8'hFB);
        close_out;
    end
endmodule // mcu_interrupt_control_tb_top

bind mic_irq_ctrl mic_irq_monitor u_mon (.hclk, .hresetn, .clk_en, .hreadyout, .hresp, .core_gie_clear,
    .core_return, .core_sleep, .core_pc, .irq_take, .stack_push, .stack_pop, .ctx_restore, .wake_req,
    .vector_addr, .return_addr, .quarter);
